// >>> rtl/aic_top.sv
// analog input control: range and pairing selection, result coding,
// limit checks, sticky flags and the alarm pin.
// assumes the serial port logic and converter share core_clk.
//
// Functional notes
// - range select bit 0 picks internal 2.25 V reference, 1 picks supply
// - two-bit pairing field selects single-ended pair, one differential or diode
// - after reset the first two inputs are single-ended channels
// - eight single-ended channels, each result ten bits wide
// - single-ended results are straight binary, step is reference/1024
// - differential results are two's complement, step is 65 mV/1024
// - bit nine is the sign; negative value is code minus 1024
// - every analog result is checked against high and low limits
// - limits hold eight bits while results hold ten
// - unmasked out-of-limit results set flags; masked ones set none
// - any unmasked flag drives the alarm pin to its active level
// - alarm polarity selectable, active low by default, all sources
// - shared pins act as diode, single-ended or differential inputs
// - after reset monitoring is off until the enable bit is set
`timescale 1ns/10ps
`include "aic_defines.svh"

module aic_top
    import aic_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // register path from the serial port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             reg_rdata_valid,
    // raw results from the converter
    input  wire logic        conv_valid,
    input  wire logic [2:0]  conv_chan,
    input  wire aic_result_t conv_raw,
    // limits, masks and polarity
    input  wire logic [63:0] limit_high_flat,
    input  wire logic [63:0] limit_low_flat,
    input  wire logic [7:0]  ain_limit_mask,
    input  wire logic        alarm_active_high,
    input  wire logic        temp_out_of_limit,
    input  wire logic        supply_out_of_limit,
    // converter and pin control
    output logic             monitor_enable_bit,
    output logic             ref_from_supply,
    output logic             diode_mode,
    output logic             diff_positive_input,
    output logic             diff_negative_input,
    // coded result
    output logic             result_valid,
    output logic [2:0]       result_chan,
    output aic_result_t      result_code,
    output logic             result_sign_bit,
    // alarm pin
    output logic             alarm_pin
);

    // register state
    logic [7:0]   control_config_first;
    logic [7:0]   control_config_third;
    logic [7:0]   alarm_flags_first;
    logic [7:0]   next_control_config_first;
    logic [7:0]   next_control_config_third;
    logic [7:0]   next_alarm_flags_first;
    logic [7:0]   next_reg_rdata;
    logic         next_reg_rdata_valid;
    aic_mon_e     mon_state;
    aic_mon_e     next_mon_state;

    // result path state
    logic         next_result_valid;
    logic [2:0]   next_result_chan;
    aic_result_t  next_result_code;
    logic         next_result_sign_bit;
    logic         next_alarm_pin;
    logic         next_ref_from_supply;
    logic         next_diode_mode;
    logic         next_diff_positive_input;
    logic         next_diff_negative_input;

    aic_pairing_e pairing;
    logic         diff_sel;
    logic         chan_diff;
    logic         chan_usable;
    aic_result_t  coded;
    logic         coded_sign;
    aic_limit_t   lim_hi;
    aic_limit_t   lim_lo;
    logic         limit_hit;
    logic [7:0]   flag_set;
    logic         flags_read;
    logic         any_alarm;

    assign pairing  = aic_pairing_e'(control_config_first[
                          `AIC_PAIRING_MSB:`AIC_PAIRING_LSB]);
    assign diff_sel = (pairing == AIC_PAIR_DIFF);

    // channel 0 carries the pair in differential mode; channel 1 is
    // absorbed, and in diode mode neither pin is an analog input
    always_comb begin
        chan_diff   = diff_sel && (conv_chan == 3'h0);
        chan_usable = 1'b1;
        if (pairing == AIC_PAIR_DIODE && conv_chan <= 3'h1) begin
            chan_usable = 1'b0;
        end
        if (diff_sel && conv_chan == 3'h1) begin
            chan_usable = 1'b0;
        end
        lim_hi = limit_high_flat[conv_chan*8 +: 8];
        lim_lo = limit_low_flat[conv_chan*8 +: 8];
    end

    aic_result_code u_code (
        .raw_code      (conv_raw),
        .diff_mode     (chan_diff),
        .out_code_sign (coded_sign),
        .out_code      (coded)
    );

    aic_limit_cmp u_cmp (
        .code         (coded),
        .signed_mode  (chan_diff),
        .limit_high   (lim_hi),
        .limit_low    (lim_lo),
        .out_of_limit (limit_hit)
    );

    // monitoring state follows the enable bit
    always_comb begin
        next_mon_state = mon_state;
        case (mon_state)
            AIC_MON_IDLE: begin
                if (control_config_first[`AIC_MONITOR_ENABLE_POS]) begin
                    next_mon_state = AIC_MON_RUN;
                end
            end
            AIC_MON_RUN: begin
                if (!control_config_first[`AIC_MONITOR_ENABLE_POS]) begin
                    next_mon_state = AIC_MON_IDLE;
                end
            end
            default: begin
                next_mon_state = AIC_MON_IDLE;
            end
        endcase
    end

    // registers, flags and read data
    always_comb begin
        next_control_config_first = control_config_first;
        next_control_config_third = control_config_third;
        next_reg_rdata            = reg_rdata;
        next_reg_rdata_valid      = 1'b0;
        flags_read                = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                `AIC_OFS_CONTROL_CONFIG_FIRST: begin
                    next_control_config_first = reg_wdata;
                end
                `AIC_OFS_CONTROL_CONFIG_THIRD: begin
                    next_control_config_third = reg_wdata;
                end
                default: begin
                    next_control_config_first = control_config_first;
                end
            endcase
        end
        if (reg_rd) begin
            next_reg_rdata_valid = 1'b1;
            case (reg_addr)
                `AIC_OFS_ALARM_FLAGS_FIRST: begin
                    next_reg_rdata = alarm_flags_first;
                    flags_read     = 1'b1;
                end
                `AIC_OFS_CONTROL_CONFIG_FIRST: begin
                    next_reg_rdata = control_config_first;
                end
                `AIC_OFS_CONTROL_CONFIG_THIRD: begin
                    next_reg_rdata = control_config_third;
                end
                default: begin
                    next_reg_rdata = 8'h00;
                end
            endcase
        end

        // a masked channel never raises its flag
        flag_set = 8'h00;
        if (conv_valid && mon_state == AIC_MON_RUN && chan_usable
                && limit_hit && !ain_limit_mask[conv_chan]) begin
            flag_set[conv_chan] = 1'b1;
        end
        // read clears, but a flag raised in the same cycle survives
        next_alarm_flags_first = flags_read ? flag_set
                               : (alarm_flags_first | flag_set);
    end

    // result, pin control and alarm
    always_comb begin
        next_result_valid    = conv_valid && chan_usable
                               && (mon_state == AIC_MON_RUN);
        next_result_chan     = conv_chan;
        next_result_code     = coded;
        next_result_sign_bit = coded_sign;
        next_ref_from_supply =
            control_config_third[`AIC_RANGE_SELECT_POS];
        next_diode_mode          = (pairing == AIC_PAIR_DIODE);
        next_diff_positive_input = diff_sel;
        next_diff_negative_input = diff_sel;
        any_alarm = |(alarm_flags_first & ~ain_limit_mask)
                    | temp_out_of_limit | supply_out_of_limit;
        next_alarm_pin = alarm_active_high ? any_alarm
                                           : ~any_alarm;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            control_config_first <= `AIC_RST_CONTROL_CONFIG_FIRST;
            control_config_third <= `AIC_RST_CONTROL_CONFIG_THIRD;
            alarm_flags_first    <= `AIC_RST_ALARM_FLAGS_FIRST;
            mon_state            <= AIC_MON_IDLE;
            reg_rdata            <= 8'h00;
            reg_rdata_valid      <= 1'b0;
            result_valid         <= 1'b0;
            result_chan          <= 3'h0;
            result_code          <= '0;
            result_sign_bit      <= 1'b0;
            monitor_enable_bit   <= 1'b0;
            ref_from_supply      <= 1'b0;
            diode_mode           <= 1'b0;
            diff_positive_input  <= 1'b0;
            diff_negative_input  <= 1'b0;
            alarm_pin            <= 1'b1;
        end else begin
            control_config_first <= next_control_config_first;
            control_config_third <= next_control_config_third;
            alarm_flags_first    <= next_alarm_flags_first;
            mon_state            <= next_mon_state;
            reg_rdata            <= next_reg_rdata;
            reg_rdata_valid      <= next_reg_rdata_valid;
            result_valid         <= next_result_valid;
            result_chan          <= next_result_chan;
            result_code          <= next_result_code;
            result_sign_bit      <= next_result_sign_bit;
            monitor_enable_bit   <= (next_mon_state == AIC_MON_RUN);
            ref_from_supply      <= next_ref_from_supply;
            diode_mode           <= next_diode_mode;
            diff_positive_input  <= next_diff_positive_input;
            diff_negative_input  <= next_diff_negative_input;
            alarm_pin            <= next_alarm_pin;
        end
    end

endmodule : aic_top

// >>> pkg/aic_defines.svh
// register offsets, field positions and reset values for the analog
// input coding and limit alarm block; definitions only
`ifndef AIC_DEFINES_SVH
`define AIC_DEFINES_SVH

// register offsets on the serial-port register path
`define AIC_OFS_ALARM_FLAGS_FIRST    8'h00
`define AIC_OFS_CONTROL_CONFIG_FIRST 8'h18
`define AIC_OFS_CONTROL_CONFIG_THIRD 8'h1A

// control_config_first fields
`define AIC_MONITOR_ENABLE_POS       0
`define AIC_PAIRING_LSB              1
`define AIC_PAIRING_MSB              2

// control_config_third fields
`define AIC_RANGE_SELECT_POS         4

// reset values
`define AIC_RST_CONTROL_CONFIG_FIRST 8'h00
`define AIC_RST_CONTROL_CONFIG_THIRD 8'h00
`define AIC_RST_ALARM_FLAGS_FIRST    8'h00

// converter geometry
`define AIC_CHAN_COUNT               8
`define AIC_RESULT_W                 10
`define AIC_LIMIT_W                  8
`define AIC_SIGN_POS                 9
`define AIC_CODE_STEPS               1024

`endif

// >>> pkg/aic_pkg.sv
// types for the analog input coding and limit alarm block
// assumes aic_defines.svh sits on the include path
`include "aic_defines.svh"

package aic_pkg;

    typedef logic [`AIC_RESULT_W-1:0] aic_result_t;
    typedef logic [`AIC_LIMIT_W-1:0]  aic_limit_t;

    // pairing field codes of the first two inputs
    typedef enum logic [1:0] {
        AIC_PAIR_SINGLE = 2'b00,
        AIC_PAIR_DIFF   = 2'b01,
        AIC_PAIR_DIODE  = 2'b10,
        AIC_PAIR_RSVD   = 2'b11
    } aic_pairing_e;

    // monitoring state, one-hot
    typedef enum logic [1:0] {
        AIC_MON_IDLE = 2'b01,
        AIC_MON_RUN  = 2'b10
    } aic_mon_e;

endpackage : aic_pkg

// >>> rtl/aic_result_code.sv
// output coding of one raw conversion result
// assumes the converter delivers differential codes offset by mid-scale
`timescale 1ns/10ps
`include "aic_defines.svh"

module aic_result_code
    import aic_pkg::*;
(
    // raw result
    input  wire aic_result_t raw_code,
    input  wire logic        diff_mode,
    // coded result
    output logic             out_code_sign,
    output aic_result_t      out_code
);

    // single-ended stays straight binary; differential turns offset
    // binary into two's complement by flipping the top bit
    always_comb begin
        out_code = raw_code;
        if (diff_mode) begin
            out_code[`AIC_SIGN_POS] = ~raw_code[`AIC_SIGN_POS];
        end
        out_code_sign = diff_mode & out_code[`AIC_SIGN_POS];
    end

endmodule : aic_result_code

// >>> rtl/aic_limit_cmp.sv
// window comparison of one coded result against 8-bit limits
// assumes limits are coded like the top 8 bits of the result
`timescale 1ns/10ps
`include "aic_defines.svh"

module aic_limit_cmp
    import aic_pkg::*;
(
    // coded result and limits
    input  wire aic_result_t code,
    input  wire logic        signed_mode,
    input  wire aic_limit_t  limit_high,
    input  wire aic_limit_t  limit_low,
    // comparison outcome
    output logic             out_of_limit
);

    aic_limit_t top_bits;
    logic       above;
    logic       below;

    // only the eight msbs meet the limits; the two lsbs are dropped
    always_comb begin
        top_bits = code[`AIC_RESULT_W-1:`AIC_RESULT_W-`AIC_LIMIT_W];
        if (signed_mode) begin
            above = $signed(top_bits) > $signed(limit_high);
            below = $signed(top_bits) < $signed(limit_low);
        end else begin
            above = top_bits > limit_high;
            below = top_bits < limit_low;
        end
        out_of_limit = above | below;
    end

endmodule : aic_limit_cmp

// >>> verif/aic_assertions.sv
// port checker for aic_top
// assumes it is bound to aic_top, one clock domain
`timescale 1ns/10ps

module aic_assertions
    import aic_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // register path
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic        reg_rdata_valid,
    // converter and alarm inputs
    input wire logic        conv_valid,
    input wire logic [2:0]  conv_chan,
    input wire aic_result_t conv_raw,
    input wire logic        alarm_active_high,
    input wire logic        temp_out_of_limit,
    // watched outputs
    input wire logic        monitor_enable_bit,
    input wire logic        ref_from_supply,
    input wire logic        diff_positive_input,
    input wire logic        result_valid,
    input wire logic [2:0]  result_chan,
    input wire aic_result_t result_code,
    input wire logic        result_sign_bit,
    input wire logic        alarm_pin
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_read_answer: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read strobe got no answer");
    a_mon_write: assert property (reg_wr && reg_addr == 8'h18
        ##1 !(reg_wr && reg_addr == 8'h18)
        |=> monitor_enable_bit == $past(reg_wdata[0], 2))
        else $error("monitor enable not taken from write");
    a_range_write: assert property (reg_wr && reg_addr == 8'h1A
        ##1 !(reg_wr && reg_addr == 8'h1A)
        |=> ref_from_supply == $past(reg_wdata[4], 2))
        else $error("reference select not taken from write");
    a_mon_gate: assert property (conv_valid && !monitor_enable_bit
        |=> !result_valid)
        else $error("result passed while monitoring off");
    a_single_code: assert property (conv_valid && conv_chan > 3'h1
        && monitor_enable_bit && $past(monitor_enable_bit)
        |=> result_valid && result_code == $past(conv_raw))
        else $error("single-ended code not straight binary");
    a_diff_drop: assert property (conv_valid && conv_chan == 3'h1
        && diff_positive_input |=> !result_valid)
        else $error("second input used while paired");
    a_sign_bit: assert property (result_valid |-> result_sign_bit ==
        (diff_positive_input && result_chan == 3'h0 && result_code[9]))
        else $error("sign bit wrong");
    a_alarm_high: assert property (temp_out_of_limit &&
        alarm_active_high ##1 alarm_active_high |-> alarm_pin)
        else $error("alarm not driven high");
    a_alarm_low: assert property (temp_out_of_limit &&
        !alarm_active_high ##1 !alarm_active_high |-> !alarm_pin)
        else $error("alarm not driven low");

    cover property (result_valid && result_sign_bit);
    cover property (reg_rdata_valid);
    cover property (alarm_pin && alarm_active_high);
endmodule : aic_assertions

// >>> verif/aic_host_model.sv
// serial-port host model issuing register strobes
// assumes tasks are entered just after a rising edge
`timescale 1ns/10ps

module aic_host_model (
    // clock and answer
    input wire logic  core_clk,
    input wire logic [7:0] reg_rdata,
    input wire logic  reg_rdata_valid,
    // requests
    output logic [7:0] reg_addr,
    output logic       reg_wr,
    output logic [7:0] reg_wdata,
    output logic       reg_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // released lines show the inverse, so stale data never matches
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        ok       = reg_rdata_valid;
        d        = reg_rdata;
        // one quiet edge so a following request never reuses this step
        @(posedge core_clk);
        #1;
    endtask : rd_reg
endmodule : aic_host_model

// >>> verif/tb_top.sv
// self-checking bench for aic_top with a reference model
// assumes package, host model and checker compile first
`timescale 1ns/10ps

module tb_top;
    import aic_pkg::*;
    logic        core_clk = 1'b0, nrst = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_d;
    logic        reg_wr, reg_rd, reg_rdata_valid, ok;
    logic        conv_valid = 1'b0;
    logic [2:0]  conv_chan = 3'h0;
    aic_result_t conv_raw = 10'h000, result_code;
    logic [63:0] limit_high_flat = 64'h0, limit_low_flat = 64'h0;
    logic [7:0]  ain_limit_mask = 8'h00, exp_flags = 8'h00;
    logic        alarm_active_high = 1'b0, temp_out_of_limit = 1'b0;
    logic        supply_out_of_limit = 1'b0, en_m = 1'b0;
    logic        diff_m = 1'b0, diode_m = 1'b0;
    logic        monitor_enable_bit, ref_from_supply, diode_mode;
    logic        diff_positive_input, diff_negative_input;
    logic        result_valid, result_sign_bit, alarm_pin;
    logic [2:0]  result_chan;
    logic [15:0] lfsr = 16'h48DC;
    int          errors = 0, cmp_count = 0;

    always #20 core_clk = ~core_clk;

    aic_top uut (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .reg_rdata_valid, .conv_valid, .conv_chan,
        .conv_raw, .limit_high_flat, .limit_low_flat, .ain_limit_mask,
        .alarm_active_high, .temp_out_of_limit, .supply_out_of_limit,
        .monitor_enable_bit, .ref_from_supply, .diode_mode,
        .diff_positive_input, .diff_negative_input, .result_valid,
        .result_chan, .result_code, .result_sign_bit, .alarm_pin);
    aic_host_model host (.core_clk, .reg_rdata, .reg_rdata_valid,
        .reg_addr, .reg_wr, .reg_wdata, .reg_rd);

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("TB: %0d compares, %0d errors", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd_reg(a, rd_d, ok);
        chk(ok, 1'b1);
        chk(rd_d, e);
    endtask : rdchk

    // extra idle cycle: results count only from two cycles after a write
    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        host.wr_reg(a, d);
        @(posedge core_clk);
        #1;
    endtask : cfg

    task automatic conv(input logic [2:0] ch, input aic_result_t raw);
        logic dif, drop;
        logic [9:0] code;
        logic signed [8:0] t, h, l;
        dif  = diff_m && ch == 3'h0;
        drop = !en_m || (diode_m && ch < 3'h2) || (diff_m && ch == 3'h1);
        code = dif ? raw ^ 10'h200 : raw;
        t = {dif & code[9], code[9:2]};
        h = {dif & limit_high_flat[ch*8+7], limit_high_flat[ch*8 +: 8]};
        l = {dif & limit_low_flat[ch*8+7], limit_low_flat[ch*8 +: 8]};
        conv_chan  = ch;
        conv_raw   = raw;
        conv_valid = 1'b1;
        @(posedge core_clk);
        #1;
        conv_valid = 1'b0;
        conv_raw   = ~raw;
        chk(result_valid, !drop);
        if (!drop) begin
            chk(result_code, code);
            chk(result_chan, ch);
            chk(result_sign_bit, dif & code[9]);
            if ((t > h || t < l) && !ain_limit_mask[ch])
                exp_flags[ch] = 1'b1;
        end
        @(posedge core_clk);
        #1;
        chk(alarm_pin, (|exp_flags) ^ !alarm_active_high);
    endtask : conv

    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        @(posedge core_clk);
        #1;
        chk(alarm_pin, 1'b1);
        chk({monitor_enable_bit, diode_mode, diff_positive_input}, 3'h0);
        rdchk(8'h18, 8'h00);
        rdchk(8'h1A, 8'h00);
        rdchk(8'h55, 8'h00);
        conv(3'h3, 10'h3FF);
        cfg(8'h00, 8'hFF);
        rdchk(8'h00, 8'h00);
        $display("TB: reset and idle test done");
        for (int m = 0; m < 4; m++) begin
            limit_high_flat = {rnd(), rnd(), rnd(), rnd()};
            limit_low_flat  = {rnd(), rnd(), rnd(), rnd()};
            ain_limit_mask  = 8'(rnd());
            alarm_active_high = m[0];
            cfg(8'h18, 8'(m * 2 + 1));
            cfg(8'h1A, {3'h0, m[0], 4'h0});
            en_m    = 1'b1;
            diff_m  = (m == 1);
            diode_m = (m == 2);
            chk({diff_positive_input, diff_negative_input, diode_mode,
                 ref_from_supply}, {diff_m, diff_m, diode_m, m[0]});
            rdchk(8'h18, 8'(m * 2 + 1));
            conv(3'h0, 10'h000);
            conv(3'h0, 10'h3FF);
            repeat (40) conv(3'(rnd()), 10'(rnd()));
            rdchk(8'h00, exp_flags);
            exp_flags = 8'h00;
            rdchk(8'h00, 8'h00);
            $display("TB: pairing mode %0d test done", m);
        end
        for (int p = 0; p < 4; p++) begin
            alarm_active_high   = p[0];
            temp_out_of_limit   = p[1];
            supply_out_of_limit = !p[1];
            repeat (2) @(posedge core_clk);
            #1;
            chk(alarm_pin, alarm_active_high);
        end
        $display("TB: alarm polarity test done");
        nrst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        @(posedge core_clk);
        #1;
        chk({monitor_enable_bit, diode_mode, diff_positive_input}, 3'h0);
        rdchk(8'h18, 8'h00);
        rdchk(8'h00, 8'h00);
        $display("TB: second reset test done");
        end_sim();
    end

    initial begin
        #400000;
        errors++;
        end_sim();
    end
endmodule : tb_top

bind aic_top aic_assertions chk_i (.core_clk, .nrst, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata_valid, .conv_valid, .conv_chan,
    .conv_raw, .alarm_active_high, .temp_out_of_limit,
    .monitor_enable_bit, .ref_from_supply, .diff_positive_input,
    .result_valid, .result_chan, .result_code, .result_sign_bit,
    .alarm_pin);
